// File: dacct_far_model.sv
/*
  Far-side model: a converter that answers start pulses after a variable
  delay, and pulled-up active-low backplane trigger lines.
  Assumes one clock shared with the register bank.
*/
`timescale 1ns/1ps
`default_nettype none
module dacct_far_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic adc_start,
  input wire logic [7:0] conv_val,
  input wire logic [5:0] conv_lat,
  output logic adc_done,
  output logic [7:0] adc_result,
  input wire logic [7:0] pull_n,
  input wire logic [7:0] dev_out,
  input wire logic [7:0] dev_oe_n,
  output logic [7:0] line_level
);
  // ****
  // Lines
  // ****
  int cnt;
  // Wired-AND: any party driving low wins over the pull-up
  assign line_level = pull_n & (dev_out | dev_oe_n);
  // Result bus toggles outside the done cycle so a late capture shows up
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= 0;
      adc_done <= 1'b0;
      adc_result <= 8'h5a;
    end
    else
    begin
      adc_done <= (cnt == 1);
      adc_result <= (cnt == 1) ? conv_val : ~adc_result;
      if (adc_start)
        cnt <= conv_lat;
      else if (cnt > 0)
        cnt <= cnt - 1;
    end
  end
endmodule
`default_nettype wire

// File: dacct_pkg.sv
/*
  Shared constants of the D/A module calibration and trigger register bank:
  register offsets, field positions, reset values, mode codes and timing.
  Assumes a 25 MHz system clock and 16-bit register accesses at byte offsets.
*/
package dacct_pkg;

  // ****************************************
  // Register offsets (byte offsets from base)
  // ****************************************
  localparam logic [5:0] OFF_CAL = 6'h08;
  localparam logic [5:0] OFF_CFG = 6'h0a;
  localparam logic [5:0] OFF_SWTRIG = 6'h0c;
  localparam logic [5:0] OFF_TRIG = 6'h0e;
  localparam logic [5:0] OFF_INT = 6'h12;
  localparam logic [5:0] OFF_ISO = 6'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CAL_BUS_BIT = 15;
  localparam int ADC_BUSY_BIT = 14;
  localparam int CAL_VOLT_BIT = 13;
  localparam int MUX_EN_BIT = 12;
  localparam int MUX_ADDR_LSB = 8;
  localparam int ADC_SCALE_BIT = 7;
  localparam int CFG_SIZE_LSB = 3;
  localparam int TRG_EN_BIT = 15;
  localparam int TRG_OUT_LSB = 6;
  localparam int TRG_MODE_LSB = 4;
  localparam int TRG_SRC_LSB = 0;
  localparam int INT_IGN_BIT = 9;

  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_OUTPUT = 2'h3;
  localparam logic [3:0] SRC_SW = 4'h8;
  localparam logic [3:0] SRC_EXT = 4'h9;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int RELAY_SETTLE_MS = 5;
  localparam int RELAY_SETTLE_CYC = (RELAY_SETTLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_PULSE_NS = 160;
  localparam int TRIG_PULSE_CYC = (TRIG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Output-mode line driver states
  typedef enum logic {TS_IDLE, TS_DRIVE} dacct_tstate_t;

endpackage

// File: dacct_regs.sv
/*
  Calibration and trigger register bank of a multi-channel D/A module.
  Holds calibration control, card configuration, software trigger, trigger
  control, trigger-ignored status and isolation status, and instantiates
  the trigger unit. Assumes a simple 16-bit register port with one-cycle
  read and write strobes, and an external 8-bit converter with a done pulse.
*/
// Contract
// - Cal control bit 15 connects or disconnects cal bus; reads back last write. Here a write with bit 14 set leaves it unchanged.
// - Cal control read bit 14 is one while converter busy, zero when result ready.
// - Writing one to bit 14 starts a measurement; zero mid-run corrupts it.
// - Bit 13 selects voltage (one) or current (zero); reads back last write. Here a write with bit 14 set leaves it unchanged.
// - Bit 12 enables the calibration mux; zero leaves it high impedance.
// - Bits 11..8 pick channel 1..16; effective only while mux enabled.
// - Read bits 7..0 return latest unsigned 8-bit converter result.
// - Write bit 7 selects converter range: zero normal, one divided by 13.7.
// - Configuration bits 5..3 read ones for eight channels, zeros for sixteen.
// - Configuration bits 2..0 mirror the three terminal sense lines.
// - Any write to software trigger register triggers when software source selected.
// - Trigger control bit 15 enables or disables the trigger system.
// - Trigger control bits 8..6 pick which backplane line is driven.
// - Trigger control bits 5..4: 00 sync mode, 11 output mode.
// - Trigger control bits 3..0: lines 0..7, 8 software, 9 external.
// - Sync mode accepts only the selected backplane line; output select ignored.
// - Output mode accepts selected input and drives a different output line; here the line is enabled with data held high, never pulled low.
// - Interrupt status bit 9 reads one while trigger-ignored condition exists.
// - Isolation bits read one for non-isolated or missing plug-on, zero isolating.
// - Eight-channel build reads isolation bits 15..8 as ones.
// - Pending channel values wait for a trigger event before being applied.
`timescale 1ns/1ps
`default_nettype none
module dacct_regs #(
  parameter int SETTLE_CYC = dacct_pkg::RELAY_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_ack,
  input wire logic eight_ch_build,
  input wire logic [2:0] terminal_sense_line,
  input wire logic [15:0] channel_isolation_flag,
  input wire logic adc_done,
  input wire logic [7:0] adc_result,
  output logic adc_start,
  output logic adc_scale_div,
  output logic cal_bus_connect,
  output logic cal_volt_sel,
  output logic cal_mux_en,
  output logic [3:0] cal_mux_addr,
  output logic cal_mode_settled,
  input wire logic [15:0] chan_pending,
  output logic trigger_apply,
  input wire logic [7:0] ttl_trig_n_in,
  input wire logic ext_trig_in,
  output logic [7:0] ttl_trig_n_out,
  output logic [7:0] ttl_trig_oe_n
);

  // ****************************************
  // Address decode
  // ****************************************
  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    hit = (a == off);
  endfunction

  logic wr_cal;
  logic wr_sw;
  logic wr_trig;
  logic rd_int;
  logic start_wr;

  assign wr_cal = reg_wr & hit(reg_addr, dacct_pkg::OFF_CAL);
  assign wr_sw = reg_wr & hit(reg_addr, dacct_pkg::OFF_SWTRIG);
  assign wr_trig = reg_wr & hit(reg_addr, dacct_pkg::OFF_TRIG);
  assign rd_int = reg_rd & hit(reg_addr, dacct_pkg::OFF_INT);
  // A start write is taken alone; it leaves the other calibration fields as they were
  assign start_wr = wr_cal & reg_wdata[dacct_pkg::ADC_BUSY_BIT];

  // ****************************************
  // Calibration control state
  // ****************************************
  logic cal_bus_q;
  logic cal_volt_q;
  logic mux_en_q;
  logic [3:0] mux_addr_q;
  logic scale_q;
  logic busy_q;
  logic [7:0] result_q;
  logic adc_start_q;

  // Plain field writes; a start write only touches the converter
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_bus_q <= 1'b0;
      cal_volt_q <= 1'b0;
      mux_en_q <= 1'b0;
      mux_addr_q <= 4'h0;
      scale_q <= 1'b0;
    end
    else if (wr_cal && !start_wr)
    begin
      cal_bus_q <= reg_wdata[dacct_pkg::CAL_BUS_BIT];
      cal_volt_q <= reg_wdata[dacct_pkg::CAL_VOLT_BIT];
      mux_en_q <= reg_wdata[dacct_pkg::MUX_EN_BIT];
      mux_addr_q <= reg_wdata[dacct_pkg::MUX_ADDR_LSB +: 4];
      scale_q <= reg_wdata[dacct_pkg::ADC_SCALE_BIT];
    end
  end

  // Converter handshake; a start in the done cycle wins, so busy stays set
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q <= 1'b0;
      result_q <= 8'h00;
      adc_start_q <= 1'b0;
    end
    else
    begin
      adc_start_q <= start_wr;
      if (start_wr)
        busy_q <= 1'b1;
      else if (adc_done)
        busy_q <= 1'b0;
      if (adc_done)
        result_q <= adc_result;
    end
  end

  // Pin drive: the mux address only moves while the mux is enabled
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cal_bus_connect <= 1'b0;
      cal_volt_sel <= 1'b0;
      cal_mux_en <= 1'b0;
      cal_mux_addr <= 4'h0;
      adc_scale_div <= 1'b0;
      adc_start <= 1'b0;
    end
    else
    begin
      cal_bus_connect <= cal_bus_q;
      cal_volt_sel <= cal_volt_q;
      cal_mux_en <= mux_en_q;
      if (mux_en_q)
        cal_mux_addr <= mux_addr_q;
      adc_scale_div <= scale_q;
      adc_start <= adc_start_q;
    end
  end

  // ****************************************
  // Relay settle timer
  // ****************************************
  // Informational only: software still owns the wait, this just tells it when
  logic [16:0] settle_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      settle_q <= 17'h00000;
      cal_mode_settled <= 1'b1;
    end
    else if (cal_volt_q != cal_volt_sel)
    begin
      settle_q <= 17'(SETTLE_CYC - 1);
      cal_mode_settled <= 1'b0;
    end
    else if (settle_q != 17'h00000)
      settle_q <= settle_q - 17'h00001;
    else
      cal_mode_settled <= 1'b1;
  end

  // ****************************************
  // Trigger control and status
  // ****************************************
  logic trig_en_q;
  logic [2:0] out_sel_q;
  logic [1:0] mode_q;
  logic [3:0] src_q;
  logic sw_q;
  logic ign_q;
  logic eight_q;
  dacct_trig_if tif ();

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trig_en_q <= 1'b0;
      out_sel_q <= 3'h0;
      mode_q <= dacct_pkg::MODE_SYNC;
      src_q <= 4'h0;
    end
    else if (wr_trig)
    begin
      trig_en_q <= reg_wdata[dacct_pkg::TRG_EN_BIT];
      out_sel_q <= reg_wdata[dacct_pkg::TRG_OUT_LSB +: 3];
      mode_q <= reg_wdata[dacct_pkg::TRG_MODE_LSB +: 2];
      src_q <= reg_wdata[dacct_pkg::TRG_SRC_LSB +: 4];
    end
  end

  // Software strobe and ignored flag; a new ignored event beats a clearing read
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_q <= 1'b0;
      ign_q <= 1'b0;
      eight_q <= 1'b0;
    end
    else
    begin
      sw_q <= wr_sw;
      ign_q <= tif.ignored | (ign_q & ~rd_int);
      eight_q <= eight_ch_build;
    end
  end

  assign tif.sys_en = trig_en_q;
  assign tif.out_sel = out_sel_q;
  assign tif.mode = mode_q;
  assign tif.src_sel = src_q;
  assign tif.sw_strobe = sw_q;
  assign tif.pending_any = |chan_pending;

  dacct_trig u_trig (
    .clk(clk),
    .rst_n(rst_n),
    .tif(tif),
    .ttl_trig_n_in(ttl_trig_n_in),
    .ext_trig_in(ext_trig_in),
    .ttl_trig_n_out(ttl_trig_n_out),
    .ttl_trig_oe_n(ttl_trig_oe_n)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      trigger_apply <= 1'b0;
    else
      trigger_apply <= tif.apply;
  end

  // ****************************************
  // Read path
  // ****************************************
  logic [15:0] cal_word;
  logic [15:0] cfg_word;
  logic [15:0] trig_word;
  logic [15:0] int_word;
  logic [15:0] iso_word;
  logic [15:0] rd_word;

  assign cal_word = {cal_bus_q, busy_q, cal_volt_q, mux_en_q, mux_addr_q, result_q};
  assign cfg_word = {10'h000, {3{eight_q}}, terminal_sense_line};
  assign trig_word = {trig_en_q, 6'h00, out_sel_q, mode_q, src_q};
  assign int_word = {6'h00, ign_q, 9'h000};
  assign iso_word = {eight_q ? 8'hff : channel_isolation_flag[15:8], channel_isolation_flag[7:0]};
  assign rd_word = hit(reg_addr, dacct_pkg::OFF_CAL) ? cal_word :
                   hit(reg_addr, dacct_pkg::OFF_CFG) ? cfg_word :
                   hit(reg_addr, dacct_pkg::OFF_TRIG) ? trig_word :
                   hit(reg_addr, dacct_pkg::OFF_INT) ? int_word :
                   hit(reg_addr, dacct_pkg::OFF_ISO) ? iso_word : dacct_pkg::RST_WORD;

  // Every access is answered one cycle later; unmapped reads give zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_ack <= 1'b0;
      reg_rdata <= dacct_pkg::RST_WORD;
    end
    else
    begin
      reg_ack <= reg_rd | reg_wr;
      reg_rdata <= reg_rd ? rd_word : reg_rdata;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_conv_start;
    start_wr && !adc_done;
  endsequence

  busy_on_start_a: assert property (s_conv_start |=> busy_q ##1 (cal_word[14] || $past(adc_done)))
    else $error("converter busy not raised by start write");
  result_capture_a: assert property (adc_done && !start_wr |=> !busy_q && result_q == $past(adc_result))
    else $error("converter result not latched on done");
  cal_bus_wr_a: assert property (wr_cal && !start_wr |=> ##1 cal_bus_connect == $past(reg_wdata[15], 2))
    else $error("cal bus pin does not follow write");
  start_keeps_a: assert property (start_wr |=> $stable(cal_bus_q) && $stable(mux_en_q) && $stable(cal_volt_q))
    else $error("start write disturbed calibration fields");
  mux_hold_a: assert property (!mux_en_q |=> $stable(cal_mux_addr))
    else $error("mux address moved while mux disabled");
  iso_upper_a: assert property (reg_rd && reg_addr == dacct_pkg::OFF_ISO && eight_q
    |=> reg_rdata[15:8] == 8'hff && reg_ack)
    else $error("eight-channel isolation upper byte not ones");
  ign_set_wins_a: assert property (tif.ignored |=> ign_q)
    else $error("trigger-ignored event lost");
  sw_trig_apply_a: assert property (wr_sw && trig_en_q && src_q == dacct_pkg::SRC_SW
    && mode_q == dacct_pkg::MODE_OUTPUT && |chan_pending ##1 $stable(trig_en_q) && |chan_pending
    |=> ##1 trigger_apply)
    else $error("software trigger write did not apply");

endmodule
`default_nettype wire

// File: dacct_regs_bench.sv
/*
  Self-checking bench of the calibration and trigger register bank.
  Assumes the far-side model file is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module dacct_regs_bench;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, reg_ack, eight_ch_build = 0;
  logic [5:0] reg_addr = 0, conv_lat = 6'h08;
  logic [15:0] reg_wdata = 0, reg_rdata, channel_isolation_flag = 0, chan_pending = 0, q, t, v;
  logic [2:0] terminal_sense_line = 0;
  logic adc_done, adc_start, adc_scale_div, cal_bus_connect, cal_volt_sel, cal_mux_en;
  logic cal_mode_settled, trigger_apply, ext_trig_in = 0;
  logic [7:0] adc_result, ttl_line, ttl_trig_n_out, ttl_trig_oe_n, seen_oe, pull_n = 8'hff, conv_val = 0, res;
  logic [3:0] mux_exp, cal_mux_addr;
  int fails = 0, n_checks = 0, cyc = 0, n_apply = 0, n_low = 0, n_start = 0, a, l;
  logic [15:0] corner [2] = '{16'hbf80, 16'h2300};

  dacct_regs #(.SETTLE_CYC(8)) i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .eight_ch_build(eight_ch_build), .terminal_sense_line(terminal_sense_line),
    .channel_isolation_flag(channel_isolation_flag), .adc_done(adc_done), .adc_result(adc_result),
    .adc_start(adc_start), .adc_scale_div(adc_scale_div), .cal_bus_connect(cal_bus_connect),
    .cal_volt_sel(cal_volt_sel), .cal_mux_en(cal_mux_en), .cal_mux_addr(cal_mux_addr),
    .cal_mode_settled(cal_mode_settled), .chan_pending(chan_pending), .trigger_apply(trigger_apply),
    .ttl_trig_n_in(ttl_line), .ext_trig_in(ext_trig_in), .ttl_trig_n_out(ttl_trig_n_out),
    .ttl_trig_oe_n(ttl_trig_oe_n));
  dacct_far_model i_far (.clk(clk), .rst_n(rst_n), .adc_start(adc_start), .conv_val(conv_val),
    .conv_lat(conv_lat), .adc_done(adc_done), .adc_result(adc_result), .pull_n(pull_n),
    .dev_out(ttl_trig_n_out), .dev_oe_n(ttl_trig_oe_n), .line_level(ttl_line));

  // ****
  // Clock, monitors, hang limit
  // ****
  always #20 clk = ~clk;
  // Pulse counters let checks stay off the exact edge of each pulse
  always @(posedge clk)
  begin
    cyc++;
    n_apply += (trigger_apply === 1'b1);
    n_start += (adc_start === 1'b1);
    if (ttl_trig_oe_n !== 8'hff)
    begin
      n_low++;
      seen_oe = ttl_trig_oe_n;
    end
    if (cyc == 20000)
    begin
      fails++;
      conclude();
    end
  end

  task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  // Strobe held one edge; ack and data looked at in their one cycle
  task automatic acc(input logic w, input logic [5:0] ad, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= ~w;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
    chk("ack", 16'h1, {15'h0, reg_ack});
    q = reg_rdata;
  endtask
  task automatic rdc(input string w, input logic [5:0] ad, input logic [15:0] e);
    acc(1'b0, ad, 16'h0);
    chk(w, e, q);
  endtask
  task automatic fire(input int ln);
    @(posedge clk) pull_n[ln] <= 1'b0;
    repeat (3) @(posedge clk);
    pull_n[ln] <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic trig_case(input logic [3:0] s, input logic [1:0] m, input int ea);
    t = {1'b1, 6'h0, 3'h5, m, s};
    acc(1'b1, dacct_pkg::OFF_TRIG, t);
    a = n_apply;
    l = n_low;
    if (s == dacct_pkg::SRC_EXT)
    begin
      @(posedge clk) ext_trig_in <= 1'b1;
      repeat (3) @(posedge clk);
      ext_trig_in <= 1'b0;
    end
    else
      acc(1'b1, dacct_pkg::OFF_SWTRIG, 16'($urandom));
    repeat (8) @(posedge clk);
    chk("apply", 16'(a + ea), 16'(n_apply));
    chk("drive", 16'(l + 4 * ea), 16'(n_low));
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****
  // Tests
  // ****
  initial
  begin
    void'($urandom(32'hcf98ac7b));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    chk("oe_rst", 16'hff, {8'h0, ttl_trig_oe_n});
    rdc("cal_rst", dacct_pkg::OFF_CAL, 16'h0);
    rdc("trig_rst", dacct_pkg::OFF_TRIG, 16'h0);
    rdc("unmapped", 6'h06, 16'h0);
    $display("test reset done");
    mux_exp = 0;
    res = 0;
    for (int i = 0; i < 6; i++)
    begin
      v = (i < 2) ? corner[i] : 16'($urandom) & 16'hbf80;
      acc(1'b1, dacct_pkg::OFF_CAL, v);
      rdc("cal_rd", dacct_pkg::OFF_CAL, {v[15:8], res});
      chk("cal_out", {12'h0, v[15], v[13], v[12], v[7]},
          {12'h0, cal_bus_connect, cal_volt_sel, cal_mux_en, adc_scale_div});
      if (v[12])
        mux_exp = v[11:8];
      chk("mux_addr", {12'h0, mux_exp}, {12'h0, cal_mux_addr});
      for (int k = 0; k < 50 && cal_mode_settled !== 1'b1; k++)
        @(posedge clk);
      chk("settled", 16'h1, {15'h0, cal_mode_settled});
    end
    for (int i = 0; i < 3; i++)
    begin
      conv_val <= 8'($urandom);
      conv_lat <= (i == 0) ? 6'h08 : 6'h08 + 6'($urandom % 30);
      a = n_start;
      acc(1'b1, dacct_pkg::OFF_CAL, 16'h4000);
      rdc("busy", dacct_pkg::OFF_CAL, {v[15], 1'b1, v[13:8], res});
      for (int k = 0; k < 20 && q[14] !== 1'b0; k++)
        acc(1'b0, dacct_pkg::OFF_CAL, 16'h0);
      res = conv_val;
      chk("result", {v[15], 1'b0, v[13:8], res}, q);
      chk("starts", 16'(a + 1), 16'(n_start));
    end
    $display("test converter done");
    for (int i = 0; i < 4; i++)
    begin
      eight_ch_build <= (i < 2) ? i[0] : 1'($urandom);
      terminal_sense_line <= (i == 0) ? 3'h7 : 3'($urandom);
      channel_isolation_flag <= 16'($urandom);
      repeat (3) @(posedge clk);
      rdc("config", dacct_pkg::OFF_CFG, {10'h0, {3{eight_ch_build}}, terminal_sense_line});
      rdc("isolation", dacct_pkg::OFF_ISO,
          eight_ch_build ? {8'hff, channel_isolation_flag[7:0]} : channel_isolation_flag);
    end
    $display("test config done");
    for (int s = 0; s < 8; s++)
    begin
      t = {1'b1, 6'h0, 3'(s + 1), s[0] ? dacct_pkg::MODE_OUTPUT : dacct_pkg::MODE_SYNC, 4'(s)};
      acc(1'b1, dacct_pkg::OFF_TRIG, t);
      rdc("trig_ctl", dacct_pkg::OFF_TRIG, t);
      chan_pending <= 16'($urandom) | 16'h1;
      a = n_apply;
      l = n_low;
      fire((s + 4) % 8);
      chk("other_line", 16'(a), 16'(n_apply));
      fire(s);
      chk("line_apply", 16'(a + 1), 16'(n_apply));
      chk("line_drive", 16'(s[0] ? l + 4 : l), 16'(n_low));
      if (s[0])
        chk("out_line", {8'h0, ~(8'h1 << ((s + 1) % 8))}, {8'h0, seen_oe});
    end
    trig_case(dacct_pkg::SRC_SW, dacct_pkg::MODE_OUTPUT, 1);
    chk("sw_line", 16'h00df, {8'h0, seen_oe});
    trig_case(dacct_pkg::SRC_EXT, dacct_pkg::MODE_OUTPUT, 1);
    trig_case(dacct_pkg::SRC_SW, dacct_pkg::MODE_SYNC, 0);
    acc(1'b1, dacct_pkg::OFF_TRIG, 16'h0000);
    a = n_apply;
    fire(0);
    chk("disabled", 16'(a), 16'(n_apply));
    rdc("no_ignore", dacct_pkg::OFF_INT, 16'h0);
    acc(1'b1, dacct_pkg::OFF_TRIG, 16'h8000);
    chan_pending <= 16'h0;
    fire(0);
    rdc("ignored", dacct_pkg::OFF_INT, 16'h0200);
    rdc("ign_clear", dacct_pkg::OFF_INT, 16'h0);
    chk("out_idle", 16'hff, {8'h0, ttl_trig_n_out});
    $display("test trigger done");
    conclude();
  end
endmodule
`default_nettype wire

// File: dacct_trig.sv
/*
  Trigger unit: picks the selected trigger source, accepts events while the
  trigger system is enabled and in output mode drives a backplane line high, never pulling it low.
  Assumes backplane lines are active low and synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dacct_trig (
  input wire logic clk,
  input wire logic rst_n,
  dacct_trig_if.trig tif,
  input wire logic [7:0] ttl_trig_n_in,
  input wire logic ext_trig_in,
  output logic [7:0] ttl_trig_n_out,
  output logic [7:0] ttl_trig_oe_n
);

  // ****************************************
  // Source selection
  // ****************************************
  logic [7:0] ttl_prev_q;
  logic ext_prev_q;
  logic [7:0] ttl_fall;
  logic ext_rise;
  logic is_output;
  logic src_event;
  logic accept;
  logic apply_q;
  logic ignored_q;
  logic [2:0] line_q;
  logic [2:0] cnt_q;
  dacct_pkg::dacct_tstate_t state_q;

  // One falling-edge detector per backplane line
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_edge
      assign ttl_fall[gi] = ttl_prev_q[gi] & ~ttl_trig_n_in[gi];
    end
  endgenerate

  assign ext_rise = ~ext_prev_q & ext_trig_in;
  assign is_output = (tif.mode == dacct_pkg::MODE_OUTPUT);
  // Sync mode only listens to backplane lines; output mode takes any source
  assign src_event = (tif.src_sel < dacct_pkg::SRC_SW) ? ttl_fall[tif.src_sel[2:0]] :
                     !is_output ? 1'b0 :
                     (tif.src_sel == dacct_pkg::SRC_SW) ? tif.sw_strobe :
                     (tif.src_sel == dacct_pkg::SRC_EXT) ? ext_rise : 1'b0;
  assign accept = src_event & tif.sys_en;
  assign tif.apply = apply_q;
  assign tif.ignored = ignored_q;

  // Edge history and event results
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ttl_prev_q <= 8'hff;
      ext_prev_q <= 1'b0;
      apply_q <= 1'b0;
      ignored_q <= 1'b0;
    end
    else
    begin
      ttl_prev_q <= ttl_trig_n_in;
      ext_prev_q <= ext_trig_in;
      apply_q <= accept & tif.pending_any;
      ignored_q <= accept & ~tif.pending_any;
    end
  end

  // ****************************************
  // Output-mode line driver
  // ****************************************
  // Line is latched at the event so a register write mid-pulse cannot move it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= dacct_pkg::TS_IDLE;
      cnt_q <= 3'h0;
      line_q <= 3'h0;
    end
    else
    begin
      unique case (state_q)
        dacct_pkg::TS_IDLE:
        begin
          if (accept && is_output)
          begin
            state_q <= dacct_pkg::TS_DRIVE;
            line_q <= tif.out_sel;
            cnt_q <= 3'(dacct_pkg::TRIG_PULSE_CYC - 1);
          end
        end
        dacct_pkg::TS_DRIVE:
        begin
          if (cnt_q == 3'h0)
            state_q <= dacct_pkg::TS_IDLE;
          else
            cnt_q <= cnt_q - 3'h1;
        end
      endcase
    end
  end

  // Enable low only on the selected line, but data stays 8'hff, so the enabled line is driven high, never pulled low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ttl_trig_n_out <= 8'hff;
      ttl_trig_oe_n <= 8'hff;
    end
    else
    begin
      ttl_trig_n_out <= 8'hff;
      ttl_trig_oe_n <= (state_q == dacct_pkg::TS_DRIVE) ? ~(8'h01 << line_q) : 8'hff;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_start;
    accept && is_output && state_q == dacct_pkg::TS_IDLE;
  endsequence
  sequence s_drive4;
    (ttl_trig_oe_n != 8'hff) [*4];
  endsequence

  out_pulse_len_a: assert property (s_start |-> ##2 s_drive4 ##1 (ttl_trig_oe_n == 8'hff))
    else $error("output trigger pulse has wrong length");
  sync_no_drive_a: assert property ((state_q == dacct_pkg::TS_IDLE && !(accept && is_output))
    |=> ##1 (ttl_trig_oe_n == 8'hff))
    else $error("trigger line driven without an accepted output-mode event");
  apply_on_event_a: assert property (accept && tif.pending_any |=> apply_q && !ignored_q)
    else $error("accepted trigger did not apply pending values");
  disabled_quiet_a: assert property (!tif.sys_en |=> !apply_q && !ignored_q)
    else $error("trigger acted on while system disabled");

endmodule
`default_nettype wire

// File: dacct_trig_if.sv
/*
  Carrier between the register bank and the trigger unit.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface dacct_trig_if;
  logic sys_en;
  logic [2:0] out_sel;
  logic [1:0] mode;
  logic [3:0] src_sel;
  logic sw_strobe;
  logic pending_any;
  logic apply;
  logic ignored;

  modport regs (output sys_en, output out_sel, output mode, output src_sel, output sw_strobe,
                output pending_any, input apply, input ignored);
  modport trig (input sys_en, input out_sel, input mode, input src_sel, input sw_strobe,
                input pending_any, output apply, output ignored);
endinterface
`default_nettype wire
